//--- src/jmc_jog_ctrl.sv
// Jog operating mode sequencer with its parameter registers.
// Assumes a ramp generator that runs the speed/step commands and
// reports step completion and standstill on the same clock.
module jmc_jog_ctrl
  import jmc_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = JMC_CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Parameter access port
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [15:0] par_addr,
  input  wire logic [31:0] par_wdata,
  output logic      [31:0] par_rdata,
  output logic             par_ack,
  output logic             par_err,
  // Digital input pins and their function setup
  input  wire logic [3:0]  din,
  input  wire logic        din_fast,
  input  wire logic        din_jog_en,
  input  wire logic        din_fast_en,
  // Drive context
  input  wire logic [15:0] mode_select,
  input  wire logic [15:0] drive_control_word,
  input  wire logic [15:0] ramp_velocity_limit,
  input  wire logic        quick_stop,
  input  wire logic        error_active,
  input  wire logic        standstill,
  input  wire logic        step_done,
  // Jog configuration
  input  wire logic        step_mode,
  input  wire logic [15:0] brief_ms,
  // Motion commands
  output logic             run_cont,
  output logic             step_start,
  output logic             dir_neg,
  output logic      [15:0] speed_ref,
  output logic      [31:0] step_distance,
  // Drive status
  output logic             jog_active,
  output logic      [15:0] active_mode_readback,
  output logic       [1:0] status_mode_bits,
  output logic             power_enable,
  output logic             fault_clear
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  jmc_state_t  state_q, state_d;
  logic [15:0] jog_command_q, jog_slow_speed_q, jog_fast_speed_q, jog_step_wait_q;
  logic [31:0] jog_step_distance_q;
  logic [15:0] wait_lat_q;
  logic [4:0]  sync1_q, sync2_q;
  logic        fclr_prev_q;
  logic [16:0] pre_q;
  logic [15:0] ms_q;
  logic        pos_r, neg_r, one_dir, hold_same, stop_cause, fast_sel, ms_tick;
  logic [15:0] spd_raw;
  logic        wr_ok;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Two flops on every pin before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {din_fast, din};
      sync2_q <= sync1_q;
    end
  end

  // Power enable level and fault clear pulse from inputs 0 and 1
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power_enable <= 1'b0;
      fault_clear  <= 1'b0;
      fclr_prev_q  <= 1'b0;
    end else begin
      power_enable <= din_jog_en & sync2_q[0];
      fault_clear  <= din_jog_en & sync2_q[1] & ~fclr_prev_q;
      fclr_prev_q  <= sync2_q[1];
    end
  end

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // Pins or command word as the direction source
  always_comb begin
    pos_r      = din_jog_en ? sync2_q[3] : jog_command_q[JMC_CMD_POS];
    neg_r      = din_jog_en ? sync2_q[2] : jog_command_q[JMC_CMD_NEG];
    one_dir    = pos_r ^ neg_r;
    hold_same  = dir_neg ? neg_r : pos_r;
    stop_cause = drive_control_word[JMC_CW_HALT] | quick_stop | error_active;
    fast_sel   = din_jog_en ? (din_fast_en & sync2_q[4])
                            : jog_command_q[JMC_CMD_FAST];
    spd_raw    = fast_sel ? jog_fast_speed_q : jog_slow_speed_q;
    ms_tick    = (pre_q == 17'(CYC_PER_MS - 1));
  end

  // ----------------------------------------------------------------
  // Parameter registers
  // ----------------------------------------------------------------
  // Range check of a write
  always_comb begin
    case (par_addr)
      JMC_OFS_CMD:  wr_ok = (par_wdata <= {16'h0000, JMC_CMD_MAX});
      JMC_OFS_SLOW,
      JMC_OFS_FAST: wr_ok = (par_wdata >= {16'h0000, JMC_SPD_MIN}) &&
                            (par_wdata <= {16'h0000, JMC_SPD_MAX});
      JMC_OFS_STEP: wr_ok = ~par_wdata[31];
      JMC_OFS_WAIT: wr_ok = (par_wdata >= {16'h0000, JMC_WAIT_MIN}) &&
                            (par_wdata <= {16'h0000, JMC_WAIT_MAX});
      default:      wr_ok = 1'b0;
    endcase
  end

  // Register writes, applied the next cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      jog_command_q       <= JMC_RST_CMD;
      jog_slow_speed_q    <= JMC_RST_SLOW;
      jog_fast_speed_q    <= JMC_RST_FAST;
      jog_step_distance_q <= JMC_RST_STEP;
      jog_step_wait_q     <= JMC_RST_WAIT;
    end else if (par_wr && wr_ok) begin
      case (par_addr)
        JMC_OFS_CMD:  jog_command_q       <= par_wdata[15:0];
        JMC_OFS_SLOW: jog_slow_speed_q    <= par_wdata[15:0];
        JMC_OFS_FAST: jog_fast_speed_q    <= par_wdata[15:0];
        JMC_OFS_STEP: jog_step_distance_q <= par_wdata;
        JMC_OFS_WAIT: jog_step_wait_q     <= par_wdata[15:0];
        default:      jog_command_q       <= jog_command_q;
      endcase
    end
  end

  // Read data, acknowledge and error, one cycle after the request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      par_rdata <= 32'h0000_0000;
      par_ack   <= 1'b0;
      par_err   <= 1'b0;
    end else begin
      par_ack <= par_wr | par_rd;
      par_err <= par_wr ? ~wr_ok : (par_rd & ~wr_ok & (par_addr != JMC_OFS_CMD)
                 & (par_addr != JMC_OFS_SLOW) & (par_addr != JMC_OFS_FAST)
                 & (par_addr != JMC_OFS_STEP) & (par_addr != JMC_OFS_WAIT));
      case (par_addr)
        JMC_OFS_CMD:  par_rdata <= {16'h0000, jog_command_q};
        JMC_OFS_SLOW: par_rdata <= {16'h0000, jog_slow_speed_q};
        JMC_OFS_FAST: par_rdata <= {16'h0000, jog_fast_speed_q};
        JMC_OFS_STEP: par_rdata <= jog_step_distance_q;
        JMC_OFS_WAIT: par_rdata <= {16'h0000, jog_step_wait_q};
        default:      par_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Jog sequencer
  // ----------------------------------------------------------------
  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      JMC_IDLE: if (mode_select == JMC_MODE_JOG && one_dir && !stop_cause) begin
        state_d = step_mode ? JMC_STEP : JMC_CONT;
      end
      JMC_STEP: if (stop_cause) begin
        state_d = JMC_STOP;
      end else if (step_done) begin
        state_d = (hold_same && ms_q >= brief_ms) ? JMC_WAIT : JMC_STOP;
      end
      JMC_WAIT: if (stop_cause || !hold_same) begin
        state_d = JMC_STOP;
      end else if (ms_tick && ms_q + 16'h0001 >= wait_lat_q) begin
        state_d = JMC_CONT;
      end
      JMC_CONT: if (stop_cause || !hold_same) begin
        state_d = JMC_STOP;
      end
      JMC_STOP: if (standstill) begin
        state_d = JMC_IDLE;
      end
      default: state_d = JMC_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= JMC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Millisecond timer, restarted on each state change
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= 17'h0_0000;
      ms_q  <= 16'h0000;
    end else if (state_d != state_q) begin
      pre_q <= 17'h0_0000;
      ms_q  <= 16'h0000;
    end else if (ms_tick) begin
      pre_q <= 17'h0_0000;
      ms_q  <= (ms_q == 16'hffff) ? ms_q : ms_q + 16'h0001;
    end else begin
      pre_q <= pre_q + 17'h0_0001;
    end
  end

  // Direction and step parameters latched at motion start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dir_neg       <= 1'b0;
      step_distance <= JMC_RST_STEP;
      wait_lat_q    <= JMC_RST_WAIT;
    end else if (state_q == JMC_IDLE && state_d != JMC_IDLE) begin
      dir_neg       <= neg_r;
      step_distance <= jog_step_distance_q;
      wait_lat_q    <= jog_step_wait_q;
    end
  end

  // Motion command outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_cont   <= 1'b0;
      step_start <= 1'b0;
      speed_ref  <= 16'h0000;
      jog_active <= 1'b0;
    end else begin
      run_cont   <= (state_d == JMC_CONT);
      step_start <= (state_q == JMC_IDLE) && (state_d == JMC_STEP);
      speed_ref  <= (spd_raw > ramp_velocity_limit) ? ramp_velocity_limit : spd_raw;
      jog_active <= (state_d != JMC_IDLE);
    end
  end

  // Mode readback and reserved status bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_mode_readback <= 16'h0000;
      status_mode_bits     <= 2'b00;
    end else begin
      active_mode_readback <= (state_d != JMC_IDLE) ? JMC_MODE_JOG : mode_select;
      status_mode_bits     <= 2'b00;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_cont_holds;
    run_cont && hold_same && !stop_cause |=> run_cont;
  endproperty
  a_cont_holds: assert property (p_cont_holds) else $error("continuous jog dropped");

  property p_step_pulse;
    step_start |=> !step_start;
  endproperty
  a_step_pulse: assert property (p_step_pulse) else $error("step start too long");

  property p_wait_to_cont;
    state_q == JMC_WAIT && state_d == JMC_CONT |=> run_cont && ms_q == 16'h0000;
  endproperty
  a_wait_to_cont: assert property (p_wait_to_cont) else $error("no run after wait");

  property p_clamp;
    1'b1 |=> speed_ref <= $past(ramp_velocity_limit);
  endproperty
  a_clamp: assert property (p_clamp) else $error("speed above ramp limit");

  property p_both_no_start;
    state_q == JMC_IDLE && pos_r && neg_r |=> state_q == JMC_IDLE;
  endproperty
  a_both_no_start: assert property (p_both_no_start) else $error("both bits started move");

  property p_cmd_range;
    jog_command_q <= JMC_CMD_MAX;
  endproperty
  a_cmd_range: assert property (p_cmd_range) else $error("command out of range");

  property p_latch_stable;
    state_q != JMC_IDLE && $stable(state_q) |=> $stable(step_distance) && $stable(wait_lat_q);
  endproperty
  a_latch_stable: assert property (p_latch_stable) else $error("step values changed in motion");

  property p_halt_stops;
    drive_control_word[JMC_CW_HALT] && state_q != JMC_IDLE && state_q != JMC_STOP
      |=> state_q == JMC_STOP && !run_cont ##1 !run_cont;
  endproperty
  a_halt_stops: assert property (p_halt_stops) else $error("halt did not stop");

  property p_end_standstill;
    state_q == JMC_STOP && !standstill |=> state_q == JMC_STOP;
  endproperty
  a_end_standstill: assert property (p_end_standstill) else $error("left jog before standstill");

  property p_readback;
    jog_active |-> active_mode_readback == JMC_MODE_JOG;
  endproperty
  a_readback: assert property (p_readback) else $error("readback not jog code");

  c_step: cover property (step_start ##[1:1000] state_q == JMC_WAIT);
  c_cont: cover property (state_q == JMC_IDLE ##1 state_q == JMC_CONT);
  c_halt: cover property (state_q == JMC_CONT ##1 state_q == JMC_STOP ##[1:20] state_q == JMC_IDLE);

endmodule // jmc_jog_ctrl

//--- src/jmc_pkg.sv
// Constants, register map and state codes of the jog motion controller.
// Assumes a single 100 MHz clock and the documented parameter port.
//
// Function
// - Continuous jog keeps moving while the direction request stays asserted.
// - A brief request in step jog moves one step distance in that direction.
// - A sustained step request steps, waits the wait time, then runs continuously.
// - Slow speed in RPM, range 1 to 3000, default 60, kept.
// - Fast speed in RPM, range 1 to 3000, default 180, kept.
// - Speed used is clamped to the ramp velocity limit.
// - Command bit0 positive, bit1 negative, bit2 selects fast over slow.
// - Both direction bits set together never start a motion.
// - Both bits set during a running move are ignored; motion continues.
// - Jog command is 16 bit read/write, range 0 to 7, default 0.
// - Command and speed writes take effect at once.
// - Step distance signed 32 bit, 0 to 2147483647, default 20, kept.
// - Step wait 16 bit in ms, 1 to 32767, default 500, kept.
// - Step distance and wait latch only when the next motion starts.
// - Input 2 requests negative jog, input 3 requests positive jog.
// - Input 0 enables the power stage, input 1 clears a pending error; the code does both only while din_jog_en is set.
// - An assigned fast/slow input picks the jog speed by its level; the code reads it only while din_jog_en is set.
// - Status word bits 10 and 12 are reserved in jog mode.
// - Jog ends only at standstill after release, zero command, halt, stop or error.
// - Mode code minus one selects jog; readback shows minus one while jogging.
// - Control word bit 8 stops the jog motion through halt.
package jmc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] JMC_OFS_CMD  = 16'h1b12;
  localparam logic [15:0] JMC_OFS_SLOW = 16'h2908;
  localparam logic [15:0] JMC_OFS_FAST = 16'h290a;
  localparam logic [15:0] JMC_OFS_STEP = 16'h290e;
  localparam logic [15:0] JMC_OFS_WAIT = 16'h2910;

  // ----------------------------------------------------------------
  // Reset values and legal ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] JMC_RST_CMD  = 16'h0000;
  localparam logic [15:0] JMC_RST_SLOW = 16'h003c;
  localparam logic [15:0] JMC_RST_FAST = 16'h00b4;
  localparam logic [31:0] JMC_RST_STEP = 32'h0000_0014;
  localparam logic [15:0] JMC_RST_WAIT = 16'h01f4;
  localparam logic [15:0] JMC_CMD_MAX  = 16'h0007;
  localparam logic [15:0] JMC_SPD_MIN  = 16'h0001;
  localparam logic [15:0] JMC_SPD_MAX  = 16'h0bb8;
  localparam logic [15:0] JMC_WAIT_MIN = 16'h0001;
  localparam logic [15:0] JMC_WAIT_MAX = 16'h7fff;

  // ----------------------------------------------------------------
  // Field positions and mode codes
  // ----------------------------------------------------------------
  localparam int          JMC_CMD_POS  = 0;
  localparam int          JMC_CMD_NEG  = 1;
  localparam int          JMC_CMD_FAST = 2;
  localparam int          JMC_CW_HALT  = 8;
  localparam logic [15:0] JMC_MODE_JOG = 16'hffff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int JMC_CLK_NS     = 10;
  localparam int JMC_MS_NS      = 1000000;
  localparam int JMC_CYC_PER_MS = JMC_MS_NS / JMC_CLK_NS;

  // Jog sequence states
  typedef enum logic [2:0] {
    JMC_IDLE = 3'b000,
    JMC_STEP = 3'b001,
    JMC_WAIT = 3'b010,
    JMC_CONT = 3'b011,
    JMC_STOP = 3'b100
  } jmc_state_t;

endpackage

//--- test/jmc_ramp_model.sv
// Ramp generator stand-in for the jog sequencer bench.
// Assumes the sequencer clock and an active low asynchronous reset.
module jmc_ramp_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Motion commands
  input  wire logic       run_cont,
  input  wire logic       step_start,
  input  wire logic [7:0] step_lat,
  // Motion feedback
  output logic            step_done,
  output logic            standstill
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] step_cnt_q;
  logic [2:0] coast_q;

  // Step travel, done pulse step_lat cycles after the start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_cnt_q <= 8'h00;
      step_done  <= 1'b0;
    end else begin
      step_done <= (step_cnt_q == 8'h01);
      if (step_start) begin
        step_cnt_q <= step_lat;
      end else if (step_cnt_q != 8'h00) begin
        step_cnt_q <= step_cnt_q - 8'h01;
      end
    end
  end

  // Coasting, motor settles a few cycles after motion ends
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      coast_q <= 3'h0;
    end else if (run_cont || step_cnt_q != 8'h00) begin
      coast_q <= 3'h4;
    end else if (coast_q != 3'h0) begin
      coast_q <= coast_q - 3'h1;
    end
  end

  assign standstill = (coast_q == 3'h0) && !run_cont && (step_cnt_q == 8'h00);
endmodule // jmc_ramp_model

//--- test/jmc_jog_ctrl_bench.sv
// Self-checking bench for the jog sequencer and its parameter port.
// Assumes jmc_pkg and a ten-cycle millisecond to keep waits short.
module jmc_jog_ctrl_bench
  import jmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int CPM = 10;
  logic        clk = 1'b0, rstn = 1'b0, par_wr = 1'b0, par_rd = 1'b0, din_fast = 1'b0;
  logic        din_jog_en = 1'b0, din_fast_en = 1'b0, quick_stop = 1'b0, error_active = 1'b0;
  logic        step_mode = 1'b0, run_seen = 1'b0, e;
  logic        par_ack, par_err, standstill, step_done, run_cont, step_start, dir_neg;
  logic        jog_active, power_enable, fault_clear;
  logic [1:0]  status_mode_bits;
  logic [3:0]  din = 4'h0;
  logic [7:0]  step_lat = 8'h0c;
  logic [15:0] par_addr = 16'h0, mode_select = 16'h0, drive_control_word = 16'h0;
  logic [15:0] ramp_velocity_limit = 16'h0bb8, brief_ms = 16'h0002;
  logic [15:0] speed_ref, active_mode_readback;
  logic [31:0] par_wdata = 32'h0, seed = 32'h6, par_rdata, step_distance, rdv, d1, d2;
  logic [15:0] offs [6] = '{JMC_OFS_CMD, JMC_OFS_SLOW, JMC_OFS_FAST, JMC_OFS_STEP,
                            JMC_OFS_WAIT, 16'h1000};
  logic [31:0] sh [6] = '{32'h0, 32'h3c, 32'hb4, 32'h14, 32'h1f4, 32'h0};
  logic [31:0] cv [11] = '{32'h7, 32'h8, 32'h0, 32'h1, 32'hbb8, 32'hbb9, 32'h7fff_ffff,
                           32'h8000_0000, 32'h0, 32'h7fff, 32'h8000};
  logic [31:0] msk [4] = '{32'hf, 32'hfff, 32'h7fff, 32'hffff_ffff};
  int          ci [11] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 4};
  int          fail_count = 0, samples_checked = 0, n;

  jmc_jog_ctrl #(.CYC_PER_MS(CPM)) jmc_jog_ctrl_inst (
    .clk, .rstn, .par_wr, .par_rd, .par_addr, .par_wdata, .par_rdata, .par_ack, .par_err,
    .din, .din_fast, .din_jog_en, .din_fast_en, .mode_select, .drive_control_word,
    .ramp_velocity_limit, .quick_stop, .error_active, .standstill, .step_done, .step_mode,
    .brief_ms, .run_cont, .step_start, .dir_neg, .speed_ref, .step_distance, .jog_active,
    .active_mode_readback, .status_mode_bits, .power_enable, .fault_clear
  );
  jmc_ramp_model jmc_ramp_model_inst (
    .clk, .rstn, .run_cont, .step_start, .step_lat, .step_done, .standstill
  );

  // Clock and run monitor
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (run_cont) run_seen <= 1'b1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Value accepted by register i
  function automatic logic legal(input int i, input logic [31:0] d);
    case (i)
      0: return d <= 32'h7;
      1, 2: return d >= 32'h1 && d <= 32'hbb8;
      3: return !d[31];
      4: return d >= 32'h1 && d <= 32'h7fff;
      default: return 1'b0;
    endcase
  endfunction
  // Speed after the ramp limit clamp
  function automatic logic [31:0] spd(input logic [31:0] v);
    return (v > {16'h0, ramp_velocity_limit}) ? {16'h0, ramp_velocity_limit} : v;
  endfunction
  function automatic logic pick(input int s);
    case (s)
      0: return run_cont;
      1: return jog_active;
      2: return step_start;
      3: return fault_clear;
      default: return step_done;
    endcase
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One parameter access, ack checked just after the taking edge
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic ee);
    @(posedge clk);
    #1;
    par_wr = w;
    par_rd = !w;
    par_addr = a;
    par_wdata = d;
    @(posedge clk);
    #1;
    par_wr = 1'b0;
    par_rd = 1'b0;
    rdv = par_rdata;
    check({31'h0, par_ack}, 32'h1);
    check({31'h0, par_err}, {31'h0, ee});
  endtask
  // Write, then read back against the shadow copy
  task automatic put(input int i, input logic [31:0] d);
    e = legal(i, d);
    acc(1'b1, offs[i], d, !e);
    if (e) sh[i] = d;
    acc(1'b0, offs[i], 32'h0, i == 5);
    check(rdv, sh[i]);
  endtask
  task automatic wait_sig(input int s, input logic v, input int lim);
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    check({31'h0, pick(s)}, {31'h0, v});
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, offs[i], 32'h0, i == 5);
      check(rdv, sh[i]);
    end
    // Range corners, then random writes
    for (int k = 0; k < 50; k++) begin
      n = (k < 11) ? ci[k] : int'(rnd() % 6);
      put(n, (k < 11) ? cv[k] : rnd() & msk[rnd() % 4]);
    end
    // Speed selection and clamp
    for (int k = 0; k < 8; k++) begin
      ramp_velocity_limit = 16'(rnd() % 3200);
      put(1, rnd() % 3000 + 1);
      put(2, rnd() % 3000 + 1);
      put(0, {29'h0, k[0], 2'h0});
      check(spd(k[0] ? sh[2] : sh[1]), {16'h0, speed_ref});
    end
    // Continuous jog and each stop cause
    ramp_velocity_limit = 16'h0bb8;
    mode_select = JMC_MODE_JOG;
    for (int k = 0; k < 4; k++) begin
      acc(1'b1, JMC_OFS_CMD, k[0] ? 32'h2 : 32'h5, 1'b0);
      wait_sig(0, 1'b1, 4);
      check({31'h0, dir_neg}, {31'h0, k[0]});
      check({16'h0, active_mode_readback}, 32'hffff);
      acc(1'b1, JMC_OFS_CMD, 32'h3, 1'b0);
      repeat (20) @(posedge clk);
      #1;
      check({31'h0, run_cont}, 32'h1);
      check({31'h0, dir_neg}, {31'h0, k[0]});
      check({30'h0, status_mode_bits}, 32'h0);
      case (k)
        0: acc(1'b1, JMC_OFS_CMD, 32'h0, 1'b0);
        1: drive_control_word = 16'h0100;
        2: quick_stop = 1'b1;
        default: error_active = 1'b1;
      endcase
      wait_sig(0, 1'b0, 3);
      wait_sig(1, 1'b0, 20);
      drive_control_word = 16'h0;
      quick_stop = 1'b0;
      error_active = 1'b0;
      acc(1'b1, JMC_OFS_CMD, 32'h0, 1'b0);
    end
    // Both directions from idle
    acc(1'b1, JMC_OFS_CMD, 32'h3, 1'b0);
    repeat (6) @(posedge clk);
    #1;
    check({31'h0, jog_active}, 32'h0);
    acc(1'b1, JMC_OFS_CMD, 32'h0, 1'b0);
    // Brief step, then sustained step with late parameter writes
    step_mode = 1'b1;
    d1 = rnd() & 32'h7fff_ffff;
    d2 = rnd() & 32'h7fff_ffff;
    put(3, d1);
    put(4, 32'h3);
    acc(1'b1, JMC_OFS_CMD, 32'h1, 1'b0);
    wait_sig(2, 1'b1, 3);
    check(step_distance, d1);
    acc(1'b1, JMC_OFS_STEP, d2, 1'b0);
    acc(1'b1, JMC_OFS_CMD, 32'h0, 1'b0);
    run_seen = 1'b0;
    wait_sig(1, 1'b0, 40);
    check({31'h0, run_seen}, 32'h0);
    // Request held, but shorter than the brief threshold: steps only
    brief_ms = 16'h0064;
    run_seen = 1'b0;
    acc(1'b1, JMC_OFS_CMD, 32'h1, 1'b0);
    wait_sig(4, 1'b1, 30);
    repeat (40) @(posedge clk);
    #1;
    check({31'h0, run_seen}, 32'h0);
    acc(1'b1, JMC_OFS_CMD, 32'h0, 1'b0);
    wait_sig(1, 1'b0, 40);
    brief_ms = 16'h0002;
    step_lat = 8'h28;
    acc(1'b1, JMC_OFS_CMD, 32'h1, 1'b0);
    wait_sig(2, 1'b1, 3);
    check(step_distance, d2);
    acc(1'b1, JMC_OFS_WAIT, 32'h6, 1'b0);
    wait_sig(4, 1'b1, 60);
    wait_sig(0, 1'b1, 100);
    check({31'h0, n >= 2 * CPM && n <= 3 * CPM + 3}, 32'h1);
    check({31'h0, dir_neg}, 32'h0);
    acc(1'b1, JMC_OFS_CMD, 32'h0, 1'b0);
    wait_sig(1, 1'b0, 20);
    step_mode = 1'b0;
    // Pin-driven jog with fast/slow input
    din_jog_en = 1'b1;
    din_fast_en = 1'b1;
    for (int k = 0; k < 2; k++) begin
      din_fast = 1'(rnd() % 2);
      din = k[0] ? 4'b0101 : 4'b1001;
      wait_sig(0, 1'b1, 8);
      check({31'h0, dir_neg}, {31'h0, k[0]});
      check({31'h0, power_enable}, 32'h1);
      check(spd(din_fast ? sh[2] : sh[1]), {16'h0, speed_ref});
      din = 4'b0010;
      wait_sig(3, 1'b1, 8);
      wait_sig(1, 1'b0, 20);
      check({31'h0, power_enable}, 32'h0);
    end
    final_report();
  end
endmodule // jmc_jog_ctrl_bench
